// ==== design/acsc_consts.svh ====
// offsets, field positions, reset values and conversion counts
// assumes inclusion by bare name from the package and the testbench
`ifndef ACSC_CONSTS_SVH
`define ACSC_CONSTS_SVH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define ACSC_OFF_CTRL        8'h00
`define ACSC_OFF_STATUS      8'h04
`define ACSC_OFF_TIMING      8'h08
`define ACSC_OFF_IRQ_STAT    8'h0c
`define ACSC_OFF_IRQ_MASK    8'h10
`define ACSC_OFF_RIGHT_U     8'h40
`define ACSC_OFF_LEFT_S      8'h60
`define ACSC_OFF_LEFT_U      8'h80
`define ACSC_SLOT_SPAN       8'h20

// ****************************************************************
// field positions
// ****************************************************************
`define ACSC_CTRL_REPEAT_BIT 6
`define ACSC_CTRL_SWEEP_BIT  5
`define ACSC_CTRL_EIGHT_BIT  4
`define ACSC_STAT_DONE_BIT   15
`define ACSC_STAT_PTR_LSB    8
`define ACSC_STAT_PTR_MSB    10
`define ACSC_STAT_SLOT_MSB   7

// ****************************************************************
// reset values
// ****************************************************************
`define ACSC_CTRL_RESET      7'h00
`define ACSC_TIMING_RESET    8'h01
`define ACSC_IRQ_MASK_RESET  2'h0

// ****************************************************************
// conversion timing in converter clocks
// ****************************************************************
`define ACSC_INIT_CLKS       5'h02
`define ACSC_XFER_CLKS       5'h02
`define ACSC_RES8_CLKS       5'h0a
`define ACSC_RES10_CLKS      5'h0c
`define ACSC_FINAL_BASE      5'h02

// ****************************************************************
// bus responses
// ****************************************************************
`define ACSC_RESP_OKAY       2'h0
`define ACSC_RESP_SLVERR     2'h2

`endif

// ==== design/acsc_pkg.sv ====
// types shared by the sequencer and the conversion engine
// assumes acsc_consts.svh is on the include path
package acsc_pkg;
`include "acsc_consts.svh"

   // ****************************************************************
   // register layouts
   // ****************************************************************
   typedef struct packed {
      logic       repeat_seq;
      logic       channel_sweep_select;
      logic       eight_conversion_select;
      logic [3:0] channel_select_field;
   } acsc_ctrl_t;

   typedef struct packed {
      logic       res10;
      logic [1:0] final_sample_sel;
      logic [4:0] prescale;
   } acsc_timing_t;

   typedef struct packed {
      logic       res10;
      logic [9:0] value;
   } acsc_result_t;

   typedef enum logic [4:0] {
      ACSC_PH_IDLE  = 5'h01,
      ACSC_PH_INIT  = 5'h02,
      ACSC_PH_XFER  = 5'h04,
      ACSC_PH_FINAL = 5'h08,
      ACSC_PH_RES   = 5'h10
   } acsc_phase_t;

endpackage

// ==== design/acsc_conv_engine.sv ====
// one conversion: prescaler, sampling/transfer/resolution phases
// assumes the converter core result arrives asynchronously on pins
`timescale 1ns/1ps
`default_nettype none
module acsc_conv_engine
   import acsc_pkg::*;
(
   input  wire logic         aclk,
   input  wire logic         aresetn,
   input  wire logic         start,
   input  wire acsc_timing_t timing,
   input  wire logic [3:0]   channel_in,
   input  wire logic [9:0]   core_result,
   output logic              sample_active,
   output logic [3:0]        channel_out,
   output logic              done,
   output acsc_result_t      result_out
);

   acsc_phase_t  phase_reg;
   logic [4:0]   pre_cnt_reg;
   logic         pre_half_reg;
   logic [4:0]   ph_cnt_reg;
   logic [9:0]   sync1_reg;
   logic [9:0]   sync2_reg;
   logic [4:0]   prs_eff;
   logic         adc_tick;
   logic         ph_end;

   // ****************************************************************
   // phase lengths
   // ****************************************************************
   function automatic logic [4:0] phase_len(acsc_phase_t ph,
                                            acsc_timing_t t);
      logic [4:0] len;
      len = `ACSC_INIT_CLKS;
      unique case (ph)
         ACSC_PH_IDLE:  len = `ACSC_INIT_CLKS;
         ACSC_PH_INIT:  len = `ACSC_INIT_CLKS;
         ACSC_PH_XFER:  len = `ACSC_XFER_CLKS;
         ACSC_PH_FINAL: len = `ACSC_FINAL_BASE << t.final_sample_sel;
         ACSC_PH_RES:   len = t.res10 ? `ACSC_RES10_CLKS
                                      : `ACSC_RES8_CLKS;
      endcase
      return len;
   endfunction

   // reserved prescale zero behaves as one
   assign prs_eff  = (timing.prescale == 5'h00) ? 5'h01 : timing.prescale;
   assign adc_tick = (phase_reg != ACSC_PH_IDLE) && pre_half_reg
                     && (pre_cnt_reg >= prs_eff);
   assign ph_end   = adc_tick
                     && (ph_cnt_reg == phase_len(phase_reg, timing) - 5'h01);

   // ****************************************************************
   // result synchroniser
   // ****************************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sync1_reg <= 10'h000;
         sync2_reg <= 10'h000;
      end else begin
         sync1_reg <= core_result;
         sync2_reg <= sync1_reg;
      end
   end

   // ****************************************************************
   // two-stage prescaler
   // ****************************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn || start || phase_reg == ACSC_PH_IDLE) begin
         pre_cnt_reg  <= 5'h00;
         pre_half_reg <= 1'b0;
      end else if (pre_cnt_reg >= prs_eff) begin
         pre_cnt_reg  <= 5'h00;
         pre_half_reg <= ~pre_half_reg;
      end else begin
         pre_cnt_reg  <= pre_cnt_reg + 5'h01;
      end
   end

   // ****************************************************************
   // phase sequence of one conversion
   // ****************************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         phase_reg   <= ACSC_PH_IDLE;
         ph_cnt_reg  <= 5'h00;
         channel_out <= 4'h0;
      end else if (start) begin
         phase_reg   <= ACSC_PH_INIT;
         ph_cnt_reg  <= 5'h00;
         channel_out <= channel_in;
      end else if (ph_end) begin
         ph_cnt_reg <= 5'h00;
         unique case (phase_reg)
            ACSC_PH_IDLE:  phase_reg <= ACSC_PH_IDLE;
            ACSC_PH_INIT:  phase_reg <= ACSC_PH_XFER;
            ACSC_PH_XFER:  phase_reg <= ACSC_PH_FINAL;
            ACSC_PH_FINAL: phase_reg <= ACSC_PH_RES;
            ACSC_PH_RES:   phase_reg <= ACSC_PH_IDLE;
         endcase
      end else if (adc_tick) begin
         ph_cnt_reg <= ph_cnt_reg + 5'h01;
      end
   end

   // ****************************************************************
   // outputs
   // ****************************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         done          <= 1'b0;
         result_out    <= '0;
         sample_active <= 1'b0;
      end else begin
         done          <= !start && ph_end && phase_reg == ACSC_PH_RES;
         sample_active <= !start
                          && (phase_reg == ACSC_PH_INIT
                              || phase_reg == ACSC_PH_FINAL);
         if (!start && ph_end && phase_reg == ACSC_PH_RES) begin
            result_out.res10 <= timing.res10;
            result_out.value <= timing.res10 ? sync2_reg
                                             : {2'b00, sync2_reg[9:2]};
         end
      end
   end

endmodule
`default_nettype wire

// ==== design/acsc_top.sv ====
// sequence control, status, result slots and AXI4-Lite register slave
// assumes an AXI4-Lite master on aclk and an analog core outside
//
// Added by the designer: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module acsc_top
   import acsc_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic [9:0]  core_result,
   output logic [3:0]       analog_channel,
   output logic             analog_sample,
   output logic             irq
);

   acsc_ctrl_t   ctrl_reg;
   acsc_timing_t timing_reg;
   acsc_result_t slot_reg [8];
   logic         seq_done_reg;
   logic [7:0]   slot_done_reg;
   logic [2:0]   ptr_reg;
   logic         running_reg;
   logic         first_reg;
   logic [1:0]   irq_stat_reg;
   logic [1:0]   irq_mask_reg;
   logic [7:0]   aw_addr_reg;
   logic [31:0]  w_data_reg;
   logic [3:0]   w_strb_reg;
   logic         do_wr;
   logic         rd_take;
   logic         seq_start;
   logic         eng_done;
   acsc_result_t eng_result;
   logic         conv_done;
   logic         is_last;
   logic         conv_start;
   logic [2:0]   ptr_next;
   logic [3:0]   chan_next;
   logic [15:0]  wr_half;
   acsc_ctrl_t   wr_ctrl;
   logic [7:0]   slot_clr;
   logic [7:0]   slot_set;
   logic [1:0]   irq_ev;

   // ****************************************************************
   // helpers
   // ****************************************************************
   function automatic logic [15:0] merge16(logic [15:0] old,
                                           logic [31:0] data,
                                           logic [3:0] strb);
      logic [15:0] m;
      m = old;
      if (strb[0]) m[7:0] = data[7:0];
      if (strb[1]) m[15:8] = data[15:8];
      return m;
   endfunction

   // source code for a slot under the given settings
   function automatic logic [3:0] source_of(acsc_ctrl_t c, logic [2:0] p);
      logic [3:0] s;
      if (!c.channel_sweep_select)
         s = c.channel_select_field;
      else if (!c.eight_conversion_select)
         s = {c.channel_select_field[3:2], p[1:0]};
      else
         s = {c.channel_select_field[3], p};
      return s;
   endfunction

   // slot number that ends a sequence
   function automatic logic [2:0] last_slot(acsc_ctrl_t c);
      return c.eight_conversion_select ? 3'h7 : 3'h3;
   endfunction

   // formats: 0 right unsigned, 1 left signed, 2 left unsigned
   function automatic logic [15:0] fmt(acsc_result_t r, logic [1:0] k);
      logic [15:0] l;
      l = r.res10 ? {r.value, 6'h00} : {r.value[7:0], 8'h00};
      if (k == 2'h0)
         l = {6'h00, r.value};
      else if (k == 2'h1)
         l[15] = ~l[15];
      return l;
   endfunction

   function automatic logic is_slot_addr(logic [7:0] a);
      return a >= `ACSC_OFF_RIGHT_U
             && a < `ACSC_OFF_LEFT_U + `ACSC_SLOT_SPAN;
   endfunction

   function automatic logic [31:0] rd_word(logic [7:0] a);
      logic [31:0] d;
      logic [7:0]  rel;
      d   = 32'h0000_0000;
      rel = a - `ACSC_OFF_RIGHT_U;
      if (a == `ACSC_OFF_CTRL)
         d = {25'h0, ctrl_reg};
      else if (a == `ACSC_OFF_STATUS)
         d = {16'h0000, seq_done_reg, 4'h0, ptr_reg, slot_done_reg};
      else if (a == `ACSC_OFF_TIMING)
         d = {24'h0, timing_reg};
      else if (a == `ACSC_OFF_IRQ_STAT)
         d = {30'h0, irq_stat_reg};
      else if (a == `ACSC_OFF_IRQ_MASK)
         d = {30'h0, irq_mask_reg};
      else if (is_slot_addr(a))
         d = {16'h0000, fmt(slot_reg[rel[4:2]], rel[6:5])};
      return d;
   endfunction

   function automatic logic is_mapped(logic [7:0] a);
      return a == `ACSC_OFF_CTRL || a == `ACSC_OFF_STATUS
             || a == `ACSC_OFF_TIMING || a == `ACSC_OFF_IRQ_STAT
             || a == `ACSC_OFF_IRQ_MASK
             || (is_slot_addr(a) && a[1:0] == 2'b00);
   endfunction

   // ****************************************************************
   // AXI4-Lite write channel
   // ****************************************************************
   assign do_wr   = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
   assign wr_half = merge16({9'h000, ctrl_reg}, w_data_reg, w_strb_reg);
   assign wr_ctrl = acsc_ctrl_t'(wr_half[6:0]);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `ACSC_RESP_OKAY;
         aw_addr_reg   <= 8'h00;
         w_data_reg    <= 32'h0000_0000;
         w_strb_reg    <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awready <= 1'b0;
            aw_addr_reg   <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wready <= 1'b0;
            w_data_reg   <= s_axi_wdata;
            w_strb_reg   <= s_axi_wstrb;
         end
         if (do_wr) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= is_mapped(aw_addr_reg) ? `ACSC_RESP_OKAY
                                                   : `ACSC_RESP_SLVERR;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   // ****************************************************************
   // AXI4-Lite read channel
   // ****************************************************************
   assign rd_take = s_axi_arvalid && s_axi_arready;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= `ACSC_RESP_OKAY;
      end else if (rd_take) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         // unmapped and unaligned reads return zero
         s_axi_rdata   <= is_mapped(s_axi_araddr) ? rd_word(s_axi_araddr)
                                                  : 32'h0000_0000;
         s_axi_rresp   <= is_mapped(s_axi_araddr) ? `ACSC_RESP_OKAY
                                                  : `ACSC_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // ****************************************************************
   // software-written registers
   // ****************************************************************
   assign seq_start = do_wr && aw_addr_reg == `ACSC_OFF_CTRL;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_reg     <= acsc_ctrl_t'(`ACSC_CTRL_RESET);
         timing_reg   <= acsc_timing_t'(`ACSC_TIMING_RESET);
         irq_mask_reg <= `ACSC_IRQ_MASK_RESET;
      end else if (do_wr) begin
         if (aw_addr_reg == `ACSC_OFF_CTRL)
            ctrl_reg <= wr_ctrl;
         if (aw_addr_reg == `ACSC_OFF_TIMING && w_strb_reg[0])
            timing_reg <= acsc_timing_t'(w_data_reg[7:0]);
         if (aw_addr_reg == `ACSC_OFF_IRQ_MASK && w_strb_reg[0])
            irq_mask_reg <= w_data_reg[1:0];
      end
   end

   // ****************************************************************
   // conversion engine
   // ****************************************************************
   // a control write in the same cycle drops that result
   assign conv_done  = eng_done && running_reg && !seq_start;
   assign is_last    = ptr_reg == last_slot(ctrl_reg);
   assign ptr_next   = is_last ? 3'h0 : ptr_reg + 3'h1;
   assign conv_start = seq_start
                       || (conv_done && (!is_last || ctrl_reg.repeat_seq));
   assign chan_next  = seq_start ? source_of(wr_ctrl, 3'h0)
                                 : source_of(ctrl_reg, ptr_next);

   acsc_conv_engine u_engine (
      .aclk          (aclk),
      .aresetn       (aresetn),
      .start         (conv_start),
      .timing        (timing_reg),
      .channel_in    (chan_next),
      .core_result   (core_result),
      .sample_active (analog_sample),
      .channel_out   (analog_channel),
      .done          (eng_done),
      .result_out    (eng_result)
   );

   // ****************************************************************
   // sequencer: pointer, run state, first-sequence tracking
   // ****************************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ptr_reg     <= 3'h0;
         running_reg <= 1'b0;
         first_reg   <= 1'b0;
      end else if (seq_start) begin
         ptr_reg     <= 3'h0;
         running_reg <= 1'b1;
         first_reg   <= 1'b1;
      end else if (conv_done) begin
         ptr_reg <= ptr_next;
         if (is_last) begin
            first_reg   <= 1'b0;
            running_reg <= ctrl_reg.repeat_seq;
         end
      end
   end

   // ****************************************************************
   // result slots and done flags
   // ****************************************************************
   always_comb begin
      slot_clr = 8'h00;
      slot_set = 8'h00;
      if (rd_take && is_slot_addr(s_axi_araddr)
          && s_axi_araddr[1:0] == 2'b00)
         slot_clr[s_axi_araddr[4:2]] = 1'b1;
      if (conv_done)
         slot_set[ptr_reg] = 1'b1;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         seq_done_reg  <= 1'b0;
         slot_done_reg <= 8'h00;
      end else if (seq_start) begin
         seq_done_reg  <= 1'b0;
         slot_done_reg <= 8'h00;
      end else begin
         slot_done_reg <= (slot_done_reg & ~slot_clr) | slot_set;
         if (conv_done && is_last && first_reg)
            seq_done_reg <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int i = 0; i < 8; i++) begin
            slot_reg[i] <= '0;
         end
      end else if (conv_done) begin
         slot_reg[ptr_reg] <= eng_result;
      end
   end

   // ****************************************************************
   // interrupts: bit 0 sequence done, bit 1 slot done
   // ****************************************************************
   assign irq_ev = {conv_done, conv_done && is_last && first_reg};

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_stat_reg <= 2'h0;
         irq <= 1'b0;
      end else begin
         if (do_wr && aw_addr_reg == `ACSC_OFF_IRQ_STAT && w_strb_reg[0])
            irq_stat_reg <= (irq_stat_reg & ~w_data_reg[1:0]) | irq_ev;
         else
            irq_stat_reg <= irq_stat_reg | irq_ev;
         irq <= |(irq_stat_reg & irq_mask_reg);
      end
   end

endmodule
`default_nettype wire

// ==== tb/acsc_top_monitor.sv ====
// checker of bus handshakes and sampling phases of acsc_top
// assumes a bind into acsc_top, one clock domain
`timescale 1ns/1ps
`default_nettype none
module acsc_top_monitor (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic [7:0]  s_axi_awaddr,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic        s_axi_rvalid,
   input wire logic [3:0]  analog_channel,
   input wire logic        analog_sample
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // ********
   // sequences
   // ********
   sequence s_wr;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_ctl;
      s_wr ##0 (s_axi_awaddr == 8'h00);
   endsequence
   sequence s_rd;
      s_axi_arvalid && s_axi_arready;
   endsequence
   a_write_answer: assert property (s_wr |-> ##[1:2] s_axi_bvalid)
      else $error("write response missing");
   a_ctl_starts: assert property (s_ctl |-> ##[1:24] analog_sample)
      else $error("no sampling after control write");
   a_read_answer: assert property (s_rd |=> s_axi_rvalid)
      else $error("read data missing");
   a_ar_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address taken while busy");
   a_aw_busy: assert property (
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while busy");
   // an aborting control write cuts the phase while its response stands
   a_sample_span: assert property (
      $rose(analog_sample) |-> (analog_sample || s_axi_bvalid) [*8])
      else $error("sample phase too short");
   a_chan_steady: assert property (
      $changed(analog_channel) |->
         !$past(analog_sample) || s_axi_bvalid || $past(s_axi_bvalid))
      else $error("channel changed while sampling");
endmodule
bind acsc_top acsc_top_monitor acsc_top_monitor_i (.aclk, .aresetn,
   .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
   .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rvalid, .analog_channel, .analog_sample);
`default_nettype wire

// ==== tb/acsc_core_model.sv ====
// analog core stand-in: result encodes the source converted
// assumes the result is taken after the sampling phases
`timescale 1ns/1ps
`default_nettype none
module acsc_core_model (
   input  wire logic [3:0] analog_channel,
   input  wire logic       analog_sample,
   output logic      [9:0] core_result
);
   // garbage while sampling, source code twice after
   always_comb begin
      core_result = {analog_channel, analog_channel, 2'b01};
      if (analog_sample)
         core_result = ~core_result;
   end
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
// self-checking bench of acsc_top with a stand-in analog core
// assumes default timing, converter clock aclk/4; 8-bit results except in run_res10
`timescale 1ns/1ps
`default_nettype none
`include "acsc_consts.svh"
module tb_top;
   logic        aclk, aresetn, irq, analog_sample;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd_v;
   logic [3:0]  s_axi_wstrb, analog_channel;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready;
   logic [9:0]  core_result;
   int          n_mismatch, comparisons;
   acsc_top acsc_top_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .core_result,
      .analog_channel, .analog_sample, .irq);
   acsc_core_model acsc_core_model_i (.analog_channel, .analog_sample,
      .core_result);
   initial begin
      aclk = 1'b0;
      forever #2.5 aclk = ~aclk;
   end
   // ********
   // bus and compare tasks
   // ********
   task automatic cmp(string nm, logic [31:0] e, logic [31:0] s);
      comparisons++;
      if (s !== e) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic wr(logic [7:0] a, logic [31:0] d);
      logic aw_p, w_p;
      aw_p = 1'b1;
      w_p = 1'b1;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      // each channel released at its own handshake
      while (aw_p || w_p) begin
         @(posedge aclk);
         if (aw_p && s_axi_awready) begin
            s_axi_awvalid <= 1'b0;
            aw_p = 1'b0;
         end
         if (w_p && s_axi_wready) begin
            s_axi_wvalid <= 1'b0;
            w_p = 1'b0;
         end
      end
      do @(posedge aclk); while (!s_axi_bvalid);
      rs = s_axi_bresp;
   endtask
   task automatic rd(logic [7:0] a);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (!s_axi_rvalid);
      rd_v = s_axi_rdata;
      rs = s_axi_rresp;
   endtask
   task automatic wait_done;
      int i;
      i = 0;
      do begin
         rd(`ACSC_OFF_STATUS);
         i++;
      end while (rd_v[15] !== 1'b1 && i < 400);
   endtask
   // ********
   // scenarios
   // ********
   task automatic run_seq(logic [6:0] ctl, logic [31:0] st);
      logic [3:0] c;
      wr(`ACSC_OFF_CTRL, {25'h0, ctl});
      wait_done();
      cmp("status", st, rd_v);
      for (int k = 0; k < (ctl[4] ? 8 : 4); k++) begin
         c = !ctl[5] ? ctl[3:0] : ctl[4] ? {ctl[3], 3'(k)}
            : {ctl[3:2], 2'(k)};
         rd(8'(`ACSC_OFF_RIGHT_U + 4 * k));
         cmp("slot", {24'h0, c, c}, rd_v);
      end
      rd(`ACSC_OFF_STATUS);
      cmp("flags", 32'h8000, rd_v);
   endtask
   // 10-bit results, longest final sample, reserved prescale zero
   task automatic run_res10;
      wr(`ACSC_OFF_TIMING, 32'he0);
      wr(`ACSC_OFF_CTRL, 32'h03);
      wait_done();
      cmp("status10", 32'h800f, rd_v);
      rd(`ACSC_OFF_RIGHT_U + 8'h0c);
      cmp("right10", 32'h00cd, rd_v);
      rd(`ACSC_OFF_LEFT_U + 8'h0c);
      cmp("left10", 32'h3340, rd_v);
   endtask
   task automatic close_out;
      $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial begin
      #200us;
      n_mismatch++;
      close_out();
   end
   initial begin
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, aresetn} = '0;
      {s_axi_bready, s_axi_rready, s_axi_wstrb} = '1;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      rd(`ACSC_OFF_STATUS);
      cmp("status", 0, rd_v);
      rd(`ACSC_OFF_CTRL);
      cmp("control", 0, rd_v);
      run_seq(7'h05, 32'h800f);
      run_seq(7'h1d, 32'h80ff);
      run_seq(7'h24, 32'h800f);
      run_seq(7'h2c, 32'h800f);
      run_seq(7'h38, 32'h80ff);
      run_seq(7'h30, 32'h80ff);
      rd(`ACSC_OFF_LEFT_U + 8'h08);
      cmp("left", 32'h2200, rd_v);
      rd(`ACSC_OFF_LEFT_S + 8'h08);
      cmp("signed", 32'ha200, rd_v);
      wr(`ACSC_OFF_CTRL, 32'h44);
      wait_done();
      rd(`ACSC_OFF_RIGHT_U);
      repeat (300) @(posedge aclk);
      rd(`ACSC_OFF_STATUS);
      cmp("again", 1, {31'h0, rd_v[0]});
      rd(`ACSC_OFF_CTRL);
      cmp("control", 32'h44, rd_v);
      wr(`ACSC_OFF_CTRL, 32'h04);
      rd(`ACSC_OFF_STATUS);
      cmp("abort", 0, rd_v);
      wait_done();
      cmp("restart", 32'h800f, rd_v);
      wr(8'hfc, 1);
      cmp("wresp", `ACSC_RESP_SLVERR, rs);
      rd(8'hfc);
      cmp("rresp", `ACSC_RESP_SLVERR, rs);
      wr(`ACSC_OFF_IRQ_STAT, 3);
      run_seq(7'h05, 32'h800f);
      cmp("irq", 0, irq);
      wr(`ACSC_OFF_IRQ_MASK, 1);
      repeat (2) @(posedge aclk);
      cmp("irq", 1, irq);
      wr(`ACSC_OFF_IRQ_STAT, 1);
      repeat (2) @(posedge aclk);
      cmp("irq", 0, irq);
      run_res10();
      close_out();
   end
endmodule
`default_nettype wire
